/* File: bench/bjcd_prog_mem.sv */
// program memory model handing whole instructions to the decoder
`timescale 1ns/1ps
`default_nettype none
module bjcd_prog_mem (
   input  wire logic                  ref_clk,
   input  wire logic                  req,
   input  wire logic [15:0]           addr,
   output var  bjcd_pkg::bjcd_instr_t instr
);
   import bjcd_pkg::*;
   logic [7:0]  mem [0:65535];
   logic [23:0] last_r = 24'h00_0000;
   logic [23:0] bytes;

   task automatic load(input logic [15:0] a, input logic [7:0] b0, b1, b2);
      mem[a] = b0;
      mem[a + 16'h0001] = b1;
      mem[a + 16'h0002] = b2;
   endtask

   assign bytes = {mem[addr], mem[addr + 16'h0001], mem[addr + 16'h0002]};

   // released lines show the inverse of the last fetched bytes and of the current address
   always_ff @(posedge ref_clk) begin
      if (req) begin
         last_r <= bytes;
      end
   end

   always_comb begin
      instr.valid = req;
      instr.pc = req ? addr : ~addr;
      {instr.opcode, instr.op1, instr.op2} = req ? bytes : ~last_r;
   end
endmodule
`default_nettype wire

/* File: bench/branch_jump_ccr_decoder_test.sv */
// self-checking bench for the branch, jump and flag decoder
`timescale 1ns/1ps
`default_nettype none
module branch_jump_ccr_decoder_test;
   import bjcd_pkg::*;
   logic        ref_clk = 1'b0;
   logic        reset = 1'b1;
   logic        req = 1'b0;
   logic [15:0] fetch_pc = 16'h4f80;
   bjcd_core_t  core = '0;
   bjcd_instr_t instr;
   bjcd_res_t   res;
   bjcd_res_t   got;
   bjcd_flags_t flags;
   logic        busy;
   int          fail_count = 0;
   int          checked = 0;
   int          cycles = 0;

   always #10 ref_clk = ~ref_clk;

   bjcd_prog_mem MEM (.ref_clk(ref_clk), .req(req), .addr(fetch_pc), .instr(instr));
   bjcd_decoder DUT (.ref_clk(ref_clk), .reset(reset), .instr(instr), .core(core),
      .res(res), .flags(flags), .busy(busy));

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         wrap_up();
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("Error at %0t: got 0x%h expected 0x%h", $time, g, e);
      end
   endtask

   // one instruction: cycle count, flow change, next address, flags
   task automatic exec(input logic [7:0] op, o1, o2, input int cyc, input logic [1:0] len,
                       input logic ld, input logic [15:0] tgt, input logic [5:0] ef);
      int k;
      @(negedge ref_clk);
      MEM.load(fetch_pc, op, o1, o2);
      req = 1'b1;
      @(negedge ref_clk);
      req = 1'b0;
      chk(busy, 1'b1);
      k = 1;
      while (res.done !== 1'b1 && k < 20) begin
         @(negedge ref_clk);
         k++;
      end
      got = res;
      chk(k, cyc);
      chk(got.pc_load, ld);
      chk(got.pc_val, ld ? tgt : fetch_pc + 16'(len));
      chk(got.ret_addr, fetch_pc + 16'(len));
      chk(flags, ef);
      chk(got.illegal, 1'b0);
      chk(got.acc_wr, op == OP_FLAGS_TO_ACC);
   endtask

   task automatic setf(input logic [5:0] v);
      core.acc_a = {2'b00, v};
      exec(8'h06, 8'h00, 8'h00, 2, 2'h1, 1'b0, 16'h0000, v);
   endtask

   function automatic logic taken(input logic [3:0] c, input bjcd_flags_t f);
      case (c)
         4'h0: return 1'b1;
         4'h1: return 1'b0;
         4'h2: return !(f.c | f.z);
         4'h3: return f.c | f.z;
         4'h4: return !f.c;
         4'h5: return f.c;
         4'h6: return !f.z;
         4'h7: return f.z;
         4'h8: return !f.v;
         4'h9: return f.v;
         4'ha: return !f.n;
         4'hb: return f.n;
         4'hc: return !(f.n ^ f.v);
         4'hd: return f.n ^ f.v;
         4'he: return !(f.z | (f.n ^ f.v));
         default: return f.z | (f.n ^ f.v);
      endcase
   endfunction

   task automatic branches();
      bjcd_flags_t f;
      logic [7:0]  d;
      logic [15:0] t;
      for (int p = 0; p < 16; p++) begin
         for (int o = 0; o < 16; o++) begin
            f = {p[1], p[2], p[3:0]};
            setf(f);
            // displacement extremes reach -126 and +129 from the opcode
            d = o[0] ? 8'h80 : 8'h7f;
            t = fetch_pc + 16'h0002 + {{8{d[7]}}, d};
            exec(8'h20 | 8'(o), d, 8'h00, 3, 2'h2, taken(4'(o), f), t, f);
         end
      end
   endtask

   task automatic flow();
      core.index_x = 16'h12f0;
      core.stack_pc = 16'h3456;
      core.stack_flags = 6'h25;
      core.soft_int_vector = 16'hfff0;
      setf(6'h2b);
      exec(8'h8d, 8'hfe, 8'h00, 6, 2'h2, 1'b1, 16'h4f80, 6'h2b);
      chk(got.stack_op, STK_PUSH_RET);
      exec(8'h9d, 8'h44, 8'h00, 5, 2'h2, 1'b1, 16'h0044, 6'h2b);
      exec(8'had, 8'hf0, 8'h00, 6, 2'h2, 1'b1, 16'h13e0, 6'h2b);
      exec(8'hbd, 8'h12, 8'h34, 6, 2'h3, 1'b1, 16'h1234, 6'h2b);
      exec(8'h6e, 8'h10, 8'h00, 3, 2'h2, 1'b1, 16'h1300, 6'h2b);
      exec(8'h7e, 8'hab, 8'hcd, 3, 2'h3, 1'b1, 16'habcd, 6'h2b);
      exec(8'h39, 8'h00, 8'h00, 5, 2'h1, 1'b1, 16'h3456, 6'h2b);
      chk(got.stack_op, STK_PULL_RET);
      exec(8'h3f, 8'h00, 8'h00, 12, 2'h1, 1'b1, 16'hfff0, 6'h3b);
      chk(got.stack_op, STK_PUSH_ALL);
      exec(8'h3b, 8'h00, 8'h00, 10, 2'h1, 1'b1, 16'h3456, 6'h25);
      chk(got.stack_op, STK_PULL_ALL);
      exec(8'h3e, 8'h00, 8'h00, 9, 2'h1, 1'b0, 16'h0000, 6'h25);
      chk(res.waiting, 1'b1);
      core.wake = 1'b1;
      @(negedge ref_clk);
      chk(res.waiting, 1'b0);
      core.wake = 1'b0;
   endtask

   task automatic flag_ops();
      setf(6'h3f);
      exec(8'h0a, 8'h00, 8'h00, 2, 2'h1, 1'b0, 16'h0000, 6'h3d);
      exec(8'h0c, 8'h00, 8'h00, 2, 2'h1, 1'b0, 16'h0000, 6'h3c);
      exec(8'h0e, 8'h00, 8'h00, 2, 2'h1, 1'b0, 16'h0000, 6'h2c);
      setf(6'h00);
      exec(8'h0b, 8'h00, 8'h00, 2, 2'h1, 1'b0, 16'h0000, 6'h02);
      exec(8'h0d, 8'h00, 8'h00, 2, 2'h1, 1'b0, 16'h0000, 6'h03);
      exec(8'h0f, 8'h00, 8'h00, 2, 2'h1, 1'b0, 16'h0000, 6'h13);
      setf(6'h25);
      exec(8'h07, 8'h00, 8'h00, 2, 2'h1, 1'b0, 16'h0000, 6'h25);
      chk(got.acc_wr, 1'b1);
      chk(got.acc_val, 8'he5);
   endtask

   initial begin
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      reset = 1'b0;
      chk(flags, 6'h10);
      chk(busy, 1'b0);
      flow();
      flag_ops();
      branches();
      wrap_up();
   end
endmodule
`default_nettype wire

/* File: hdl/bjcd_decoder.sv */
// branch, jump, return and flag instruction decode and execute
// Behaviour
// RULE_01 - always-branch loads target, never-branch never does; 2 bytes, 3 cycles, flags kept
// RULE_02 - carry-test branches: 24 on carry clear, 25 on carry set; 2 bytes, 3 cycles
// RULE_03 - higher-or-same and lower share opcodes 24 and 25, same behaviour
// RULE_04 - 27 branches on zero set, 26 on zero clear
// RULE_05 - 22 branches when carry or zero is 0, 23 when it is 1
// RULE_06 - 2C/2D on n xor v 0/1, 2E/2F on z or (n xor v) 0/1
// RULE_07 - 28/29 on overflow clear/set, 2A/2B on negative clear/set; 2 bytes, 3 cycles
// RULE_08 - branch to subroutine 8D: 2 bytes, 6 cycles, flags kept
// RULE_09 - jump subroutine: 9D 5 cycles 2 bytes, AD 6/2, BD 6/3
// RULE_10 - jump 6E (2 bytes) and 7E (3 bytes), 3 cycles, flags kept
// RULE_11 - return from interrupt 3B: 1 byte, 10 cycles, all flags from stack
// RULE_12 - return from subroutine 39: 1 byte, 5 cycles, flags kept
// RULE_13 - software interrupt 3F: 1 byte, 12 cycles, sets mask only
// RULE_14 - wait 3E: 1 byte, 9 cycles then wait, flags kept
// RULE_15 - 0C clears carry, 0D sets carry; 1 byte, 2 cycles
// RULE_16 - 0E clears mask, 0F sets mask; 1 byte, 2 cycles
// RULE_17 - 0A clears overflow, 0B sets overflow; 1 byte, 2 cycles
// RULE_18 - 06 copies A into flags, 07 copies flags into A; 1 byte, 2 cycles
// RULE_19 - taken branch target is pc plus 2 plus signed displacement
// RULE_20 - flag bits 5..0 are h, i, n, z, v, c
// RULE_21 - untaken branch still takes full cycles, continues after displacement
`timescale 1ns/1ps
`default_nettype none
module bjcd_decoder (
   input  wire logic              ref_clk,
   input  wire logic              reset,
   input  wire bjcd_pkg::bjcd_instr_t instr,
   input  wire bjcd_pkg::bjcd_core_t  core,
   output var  bjcd_pkg::bjcd_res_t   res,
   output var  bjcd_pkg::bjcd_flags_t flags,
   output var  logic              busy
);
   import bjcd_pkg::*;

   typedef struct packed {
      bjcd_phase_t phase;
      logic        busy;
      logic [3:0]  cnt;
      logic [7:0]  op;
      logic [15:0] pc_first;
      logic [1:0]  len;
      logic        take;
      logic [15:0] tgt;
      bjcd_flags_t pend;
      bjcd_flags_t flag_reg;
      bjcd_res_t   res;
   } bjcd_state_t;

   localparam bjcd_state_t ST_RST = '{phase: P_IDLE, flag_reg: FLAGS_RESET, default: '0};

   bjcd_state_t st_r;
   bjcd_state_t st_nxt;
   logic        accept;

   function automatic logic branch_cond(input logic [3:0] sel, input bjcd_flags_t f);
      logic r;
      r = 1'b0;
      unique case (sel)
         4'h0: r = 1'b1;                       // RULE_01
         4'h1: r = 1'b0;                       // RULE_01
         4'h2: r = ~(f.c | f.z);               // RULE_05
         4'h3: r = f.c | f.z;                  // RULE_05
         4'h4: r = ~f.c;                       // RULE_02 RULE_03
         4'h5: r = f.c;                        // RULE_02 RULE_03
         4'h6: r = ~f.z;                       // RULE_04
         4'h7: r = f.z;                        // RULE_04
         4'h8: r = ~f.v;                       // RULE_07
         4'h9: r = f.v;                        // RULE_07
         4'hA: r = ~f.n;                       // RULE_07
         4'hB: r = f.n;                        // RULE_07
         4'hC: r = ~(f.n ^ f.v);               // RULE_06
         4'hD: r = f.n ^ f.v;                  // RULE_06
         4'hE: r = ~(f.z | (f.n ^ f.v));       // RULE_06
         4'hF: r = f.z | (f.n ^ f.v);          // RULE_06
      endcase
      return r;
   endfunction

   function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [7:0] d);
      return pc + {14'h0000, LEN_2} + {{8{d[7]}}, d};   // RULE_19
   endfunction

   assign accept = instr.valid && (st_r.phase == P_IDLE);

   always_comb begin
      st_nxt = st_r;
      st_nxt.res.done = 1'b0;
      st_nxt.res.pc_load = 1'b0;
      st_nxt.res.acc_wr = 1'b0;
      st_nxt.res.stack_op = STK_NONE;
      st_nxt.res.illegal = 1'b0;
      if (core.wake) begin
         st_nxt.res.waiting = 1'b0;
      end
      unique case (st_r.phase)
         P_IDLE: begin
            if (instr.valid) begin
               st_nxt.phase = P_EXEC;
               st_nxt.op = instr.opcode;
               st_nxt.pc_first = instr.pc;
               st_nxt.pend = st_r.flag_reg;
               st_nxt.take = 1'b0;
               st_nxt.tgt = instr.pc;
               st_nxt.len = LEN_1;
               st_nxt.cnt = CYC_FLAG - CNT_LAST;
               if (instr.opcode[7:4] == REL_HI) begin
                  st_nxt.len = LEN_2;
                  st_nxt.cnt = CYC_REL - CNT_LAST;                       // RULE_21
                  st_nxt.take = branch_cond(instr.opcode[3:0], st_r.flag_reg);
                  st_nxt.tgt = rel_target(instr.pc, instr.op1);          // RULE_19
               end else begin
                  unique case (instr.opcode)
                     OP_BRANCH_SUB: begin
                        st_nxt.len = LEN_2;
                        st_nxt.cnt = CYC_BRANCH_SUB - CNT_LAST;          // RULE_08
                        st_nxt.take = 1'b1;
                        st_nxt.tgt = rel_target(instr.pc, instr.op1);
                     end
                     OP_JUMP_SUB_DIR: begin
                        st_nxt.len = LEN_2;
                        st_nxt.cnt = CYC_JUMP_SUB_D - CNT_LAST;          // RULE_09
                        st_nxt.take = 1'b1;
                        st_nxt.tgt = {PAGE_ZERO, instr.op1};
                     end
                     OP_JUMP_SUB_IDX, OP_JUMP_IDX: begin
                        st_nxt.len = LEN_2;
                        st_nxt.cnt = (instr.opcode == OP_JUMP_IDX) ?
                                     CYC_JUMP - CNT_LAST : CYC_JUMP_SUB_IX - CNT_LAST; // RULE_09 RULE_10
                        st_nxt.take = 1'b1;
                        st_nxt.tgt = core.index_x + {PAGE_ZERO, instr.op1};
                     end
                     OP_JUMP_SUB_EXT, OP_JUMP_EXT: begin
                        st_nxt.len = LEN_3;
                        st_nxt.cnt = (instr.opcode == OP_JUMP_EXT) ?
                                     CYC_JUMP - CNT_LAST : CYC_JUMP_SUB_IX - CNT_LAST; // RULE_09 RULE_10
                        st_nxt.take = 1'b1;
                        st_nxt.tgt = {instr.op1, instr.op2};
                     end
                     OP_RET_SUB: begin
                        st_nxt.cnt = CYC_RTS - CNT_LAST;                 // RULE_12
                        st_nxt.take = 1'b1;
                        st_nxt.tgt = core.stack_pc;
                     end
                     OP_RET_INT: begin
                        st_nxt.cnt = CYC_RET_INT - CNT_LAST;             // RULE_11
                        st_nxt.take = 1'b1;
                        st_nxt.tgt = core.stack_pc;
                        st_nxt.pend = core.stack_flags;                  // RULE_11
                     end
                     OP_SOFT_INT: begin
                        st_nxt.cnt = CYC_SOFT_INT - CNT_LAST;            // RULE_13
                        st_nxt.take = 1'b1;
                        st_nxt.tgt = core.soft_int_vector;
                        st_nxt.pend.i = 1'b1;                            // RULE_13
                     end
                     OP_WAIT_INT: st_nxt.cnt = CYC_WAIT_INT - CNT_LAST;  // RULE_14
                     OP_CARRY_CLEAR: st_nxt.pend.c = 1'b0;               // RULE_15
                     OP_CARRY_SET: st_nxt.pend.c = 1'b1;                 // RULE_15
                     OP_MASK_CLEAR: st_nxt.pend.i = 1'b0;                // RULE_16
                     OP_MASK_SET: st_nxt.pend.i = 1'b1;                  // RULE_16
                     OP_OVF_CLEAR: st_nxt.pend.v = 1'b0;                 // RULE_17
                     OP_OVF_SET: st_nxt.pend.v = 1'b1;                   // RULE_17
                     OP_FLAGS_FROM_A: st_nxt.pend = bjcd_flags_t'(core.acc_a[5:0]); // RULE_18
                     OP_FLAGS_TO_ACC, OP_NOP: st_nxt.pend = st_r.flag_reg;
                     default: st_nxt.pend = st_r.flag_reg;
                  endcase
               end
            end
         end
         P_EXEC: begin
            if (st_r.cnt == CNT_LAST) begin
               st_nxt.phase = P_IDLE;
               st_nxt.flag_reg = st_r.pend;                              // RULE_20
               st_nxt.res.done = 1'b1;
               st_nxt.res.pc_load = st_r.take;                           // RULE_01
               st_nxt.res.ret_addr = st_r.pc_first + {14'h0000, st_r.len};
               st_nxt.res.pc_val = st_r.take ? st_r.tgt :
                                   st_r.pc_first + {14'h0000, st_r.len}; // RULE_21
               unique case (st_r.op)
                  OP_BRANCH_SUB, OP_JUMP_SUB_DIR, OP_JUMP_SUB_IDX, OP_JUMP_SUB_EXT:
                     st_nxt.res.stack_op = STK_PUSH_RET;
                  OP_RET_SUB: st_nxt.res.stack_op = STK_PULL_RET;
                  OP_RET_INT: st_nxt.res.stack_op = STK_PULL_ALL;
                  OP_SOFT_INT: st_nxt.res.stack_op = STK_PUSH_ALL;
                  OP_WAIT_INT: begin
                     st_nxt.res.stack_op = STK_PUSH_ALL;
                     st_nxt.res.waiting = 1'b1;                          // RULE_14
                  end
                  OP_FLAGS_TO_ACC: begin
                     st_nxt.res.acc_wr = 1'b1;                           // RULE_18
                     st_nxt.res.acc_val = {ACC_HI_PAD, st_r.flag_reg};
                  end
                  OP_NOP, OP_FLAGS_FROM_A, OP_OVF_CLEAR, OP_OVF_SET, OP_CARRY_CLEAR,
                  OP_CARRY_SET, OP_MASK_CLEAR, OP_MASK_SET, OP_JUMP_IDX, OP_JUMP_EXT:
                     st_nxt.res.stack_op = STK_NONE;
                  default: st_nxt.res.illegal = (st_r.op[7:4] != REL_HI);
               endcase
            end else begin
               st_nxt.cnt = st_r.cnt - CNT_LAST;
            end
         end
      endcase
      st_nxt.busy = (st_nxt.phase == P_EXEC);
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign res = st_r.res;
   assign flags = st_r.flag_reg;
   assign busy = st_r.busy;

   a_always_taken: assert property (@(posedge ref_clk) disable iff (reset) // RULE_01
      accept && instr.opcode == OP_BRANCH_ALWAYS |-> ##3 res.done && res.pc_load &&
      res.pc_val == $past(instr.pc, 3) + 16'h0002 + {{8{$past(instr.op1[7], 3)}},
      $past(instr.op1, 3)} && flags == $past(flags, 3))
      else $error("always-branch did not load its target");
   a_never_branch: assert property (@(posedge ref_clk) disable iff (reset) // RULE_21
      accept && instr.opcode == OP_BRANCH_NEVER |=> busy [*2] ##1
      (res.done && !res.pc_load && res.pc_val == $past(instr.pc, 3) + 16'h0002))
      else $error("never-branch timing or continuation wrong");
   a_carry_test: assert property (@(posedge ref_clk) disable iff (reset) // RULE_02
      accept && instr.opcode[7:1] == 7'h12 |-> ##3
      res.pc_load == ($past(instr.opcode[0], 3) == $past(flags.c, 3)))
      else $error("carry branch test wrong");
   a_zero_test: assert property (@(posedge ref_clk) disable iff (reset) // RULE_04
      accept && instr.opcode[7:1] == 7'h13 |-> ##3
      res.pc_load == ($past(instr.opcode[0], 3) == $past(flags.z, 3)))
      else $error("zero branch test wrong");
   a_unsigned_cmp: assert property (@(posedge ref_clk) disable iff (reset) // RULE_05
      accept && instr.opcode[7:1] == 7'h11 |-> ##3
      res.pc_load == ($past(instr.opcode[0], 3) == $past(flags.c | flags.z, 3)))
      else $error("unsigned compare branch wrong");
   a_signed_gt: assert property (@(posedge ref_clk) disable iff (reset) // RULE_06
      accept && instr.opcode[7:1] == 7'h17 |-> ##3 res.pc_load ==
      ($past(instr.opcode[0], 3) == $past(flags.z | (flags.n ^ flags.v), 3)))
      else $error("signed greater branch wrong");
   a_branch_sub_timing: assert property (@(posedge ref_clk) disable iff (reset) // RULE_08
      accept && instr.opcode == OP_BRANCH_SUB |=> !res.done [*5] ##1
      (res.done && res.stack_op == STK_PUSH_RET && flags == $past(flags, 6)))
      else $error("subroutine branch timing wrong");
   a_int_return_flags: assert property (@(posedge ref_clk) disable iff (reset) // RULE_11
      accept && instr.opcode == OP_RET_INT |-> ##10 res.done && flags == $past(core.stack_flags, 10))
      else $error("interrupt return flags not restored");
   a_soft_int_mask: assert property (@(posedge ref_clk) disable iff (reset) // RULE_13
      accept && instr.opcode == OP_SOFT_INT |-> ##12 res.done && flags.i &&
      {flags.h, flags.n, flags.z, flags.v, flags.c} ==
      $past({flags.h, flags.n, flags.z, flags.v, flags.c}, 12))
      else $error("software interrupt flag effect wrong");
   a_carry_ops: assert property (@(posedge ref_clk) disable iff (reset) // RULE_15
      accept && instr.opcode[7:1] == 7'h06 |-> ##2 res.done && flags.c == $past(instr.opcode[0], 2))
      else $error("carry set or clear wrong");
   a_flags_to_acc: assert property (@(posedge ref_clk) disable iff (reset) // RULE_18
      accept && instr.opcode == OP_FLAGS_TO_ACC |-> ##2 res.acc_wr && res.acc_val[5:0] == flags)
      else $error("flags to accumulator copy wrong");
endmodule
`default_nettype wire

/* File: hdl/bjcd_pkg.sv */
// shared types and constants for the branch, jump and flag decoder
package bjcd_pkg;

   // flag register layout, bit 5 down to bit 0
   typedef struct packed {
      logic h;
      logic i;
      logic n;
      logic z;
      logic v;
      logic c;
   } bjcd_flags_t;

   typedef enum logic [2:0] {
      STK_NONE,
      STK_PUSH_RET,
      STK_PULL_RET,
      STK_PULL_ALL,
      STK_PUSH_ALL
   } bjcd_stack_t;

   typedef enum logic {P_IDLE, P_EXEC} bjcd_phase_t;

   typedef struct packed {
      logic        valid;
      logic [7:0]  opcode;
      logic [7:0]  op1;
      logic [7:0]  op2;
      logic [15:0] pc;
   } bjcd_instr_t;

   typedef struct packed {
      logic [7:0]  acc_a;
      logic [15:0] index_x;
      logic [15:0] stack_pc;
      bjcd_flags_t stack_flags;
      logic [15:0] soft_int_vector;
      logic        wake;
   } bjcd_core_t;

   typedef struct packed {
      logic        done;
      logic        pc_load;
      logic [15:0] pc_val;
      logic        acc_wr;
      logic [7:0]  acc_val;
      bjcd_stack_t stack_op;
      logic [15:0] ret_addr;
      logic        waiting;
      logic        illegal;
   } bjcd_res_t;

   // opcodes
   localparam logic [3:0] REL_HI          = 4'h2;
   localparam logic [7:0] OP_NOP          = 8'h01;
   localparam logic [7:0] OP_FLAGS_FROM_A = 8'h06;
   localparam logic [7:0] OP_FLAGS_TO_ACC = 8'h07;
   localparam logic [7:0] OP_OVF_CLEAR    = 8'h0A;
   localparam logic [7:0] OP_OVF_SET      = 8'h0B;
   localparam logic [7:0] OP_CARRY_CLEAR  = 8'h0C;
   localparam logic [7:0] OP_CARRY_SET    = 8'h0D;
   localparam logic [7:0] OP_MASK_CLEAR   = 8'h0E;
   localparam logic [7:0] OP_MASK_SET     = 8'h0F;
   localparam logic [7:0] OP_BRANCH_ALWAYS = 8'h20;
   localparam logic [7:0] OP_BRANCH_NEVER = 8'h21;
   localparam logic [7:0] OP_RET_SUB      = 8'h39;
   localparam logic [7:0] OP_RET_INT      = 8'h3B;
   localparam logic [7:0] OP_WAIT_INT     = 8'h3E;
   localparam logic [7:0] OP_SOFT_INT     = 8'h3F;
   localparam logic [7:0] OP_JUMP_IDX     = 8'h6E;
   localparam logic [7:0] OP_JUMP_EXT     = 8'h7E;
   localparam logic [7:0] OP_BRANCH_SUB   = 8'h8D;
   localparam logic [7:0] OP_JUMP_SUB_DIR = 8'h9D;
   localparam logic [7:0] OP_JUMP_SUB_IDX = 8'hAD;
   localparam logic [7:0] OP_JUMP_SUB_EXT = 8'hBD;

   // cycle counts
   localparam logic [3:0] CYC_FLAG   = 4'h2;
   localparam logic [3:0] CYC_REL    = 4'h3;
   localparam logic [3:0] CYC_JUMP   = 4'h3;
   localparam logic [3:0] CYC_JUMP_SUB_D  = 4'h5;
   localparam logic [3:0] CYC_JUMP_SUB_IX = 4'h6;
   localparam logic [3:0] CYC_BRANCH_SUB  = 4'h6;
   localparam logic [3:0] CYC_RTS         = 4'h5;
   localparam logic [3:0] CYC_RET_INT     = 4'hA;
   localparam logic [3:0] CYC_SOFT_INT    = 4'hC;
   localparam logic [3:0] CYC_WAIT_INT    = 4'h9;
   localparam logic [3:0] CNT_LAST   = 4'h1;

   // byte lengths
   localparam logic [1:0] LEN_1 = 2'h1;
   localparam logic [1:0] LEN_2 = 2'h2;
   localparam logic [1:0] LEN_3 = 2'h3;

   localparam bjcd_flags_t FLAGS_RESET = 6'h10;
   localparam logic [1:0]  ACC_HI_PAD = 2'h3;
   localparam logic [7:0]  PAGE_ZERO  = 8'h00;

endpackage
